//--- rtl/bccd_defs.svh
// bccd_defs.svh: offsets, field positions, reset values and counts for the
// boot clock configuration decoder.
// assumes: included by bare name from files under rtl/.
`ifndef BCCD_DEFS_SVH
`define BCCD_DEFS_SVH

// ==========================================================================
// register offsets (word addresses on the plain register port)
`define BCCD_OFS_CLKWD_WORD   4'h0
`define BCCD_OFS_PLL_WORD     4'h1
`define BCCD_OFS_STATUS       4'h2
`define BCCD_OFS_WDOG_CTRL    4'h3
`define BCCD_OFS_DEC_CLK      4'h4
`define BCCD_OFS_DEC_PLL      4'h5

// ==========================================================================
// clock and watchdog word field positions
`define BCCD_WDEN_BIT         23
`define BCCD_WDPS_HI          20
`define BCCD_WDPS_LO          16
`define BCCD_CKSM_HI          15
`define BCCD_CKSM_LO          14
`define BCCD_PBDIV_HI         13
`define BCCD_PBDIV_LO         12
`define BCCD_CLOCK_OUTPUT_DIS_BIT     10
`define BCCD_POSC_HI          9
`define BCCD_POSC_LO          8
`define BCCD_TWOSPD_BIT       7
`define BCCD_SOSC_BIT         5
`define BCCD_NOSC_HI          2
`define BCCD_NOSC_LO          0

// ==========================================================================
// pll word field positions
`define BCCD_PLLODIV_HI       18
`define BCCD_PLLODIV_LO       16
`define BCCD_UPLL_BYP_BIT     15
`define BCCD_USB_PLL_INPUT_DIV_HI      10
`define BCCD_USB_PLL_INPUT_DIV_LO      8
`define BCCD_PLLMUL_HI        6
`define BCCD_PLLMUL_LO        4
`define BCCD_PLLIDIV_HI       2
`define BCCD_PLLIDIV_LO       0

// ==========================================================================
// codes and reset values
`define BCCD_WDPS_MAX         5'h14
`define BCCD_POSC_OFF         2'h3
`define BCCD_POSC_EXT         2'h0
`define BCCD_WORD_RESET       32'hffffffff
`define BCCD_CAPTURE_CYCLES   4'h2

`endif

//--- rtl/bccd_pkg.sv
// bccd_pkg.sv: types shared by the boot clock configuration decoder.
// assumes: compiled before any module that imports it.
package bccd_pkg;

  // ========================================================================
  // oscillator source and mode encodings
  typedef enum logic [2:0] {
    BCCD_SRC_FRC      = 3'b000,
    BCCD_SRC_FRC_PLL  = 3'b001,
    BCCD_SRC_POSC     = 3'b010,
    BCCD_SRC_POSC_PLL = 3'b011,
    BCCD_SRC_SOSC     = 3'b100,
    BCCD_SRC_LOW_POWER_RC_OSC     = 3'b101,
    BCCD_SRC_FRC_D16  = 3'b110,
    BCCD_SRC_FRC_DIVN = 3'b111
  } bccd_src_t;

  typedef enum logic [1:0] {
    BCCD_POSC_EC  = 2'b00,
    BCCD_POSC_XT  = 2'b01,
    BCCD_POSC_HS  = 2'b10,
    BCCD_POSC_DIS = 2'b11
  } bccd_posc_t;

  typedef enum logic [1:0] {
    BCCD_ST_RESET   = 2'b00,
    BCCD_ST_CAPTURE = 2'b01,
    BCCD_ST_HOLD    = 2'b10
  } bccd_state_t;

  // ========================================================================
  // decoded clock and watchdog settings
  typedef struct packed {
    logic       wdog_force_enable;
    logic [4:0] wdog_postscale_sel;
    logic [20:0] wdog_ratio;
    logic       clk_switch_en;
    logic       fail_safe_mon_en;
    logic [3:0] periph_bus_div_default;
    logic       clock_output_en;
    bccd_posc_t primary_osc_mode;
    logic       two_speed_startup_en;
    logic       secondary_osc_en;
    bccd_src_t  initial_osc_sel;
  } bccd_clk_cfg_t;

  // decoded pll settings
  typedef struct packed {
    logic [8:0] pll_output_div;
    logic       usb_pll_en;
    logic [3:0] usb_pll_input_div;
    logic [4:0] pll_multiplier;
    logic [3:0] pll_input_div;
  } bccd_pll_cfg_t;

endpackage

//--- rtl/bccd_field_dec.sv
// bccd_field_dec.sv: pure decode of the two configuration words.
// assumes: words are stable; outputs are registered by the parent.
`timescale 1ns/100ps
`default_nettype none
`include "bccd_defs.svh"

module bccd_field_dec
  import bccd_pkg::*;
(
  input  wire logic [31:0]  clk_wd_word,
  input  wire logic [31:0]  pll_word,
  output var bccd_clk_cfg_t clk_cfg,
  output var bccd_pll_cfg_t pll_cfg
);

  logic [4:0]  ps_code;
  logic [1:0]  cksm;
  logic [1:0]  posc;
  logic [2:0]  odiv;

  // =========================================================================
  // divider lookups shared by both pll input dividers
  function automatic logic [3:0] in_div(input logic [2:0] c);
    case (c)
      3'h6:    in_div = 4'ha;
      3'h7:    in_div = 4'hc;
      default: in_div = {1'b0, c} + 4'h1;
    endcase
  endfunction

  // =========================================================================
  // clock and watchdog word decode
  always_comb begin
    ps_code = clk_wd_word[`BCCD_WDPS_HI:`BCCD_WDPS_LO];
    cksm    = clk_wd_word[`BCCD_CKSM_HI:`BCCD_CKSM_LO];
    posc    = clk_wd_word[`BCCD_POSC_HI:`BCCD_POSC_LO];
    clk_cfg.wdog_force_enable = clk_wd_word[`BCCD_WDEN_BIT];
    // out-of-range codes fold to the largest ratio
    if (ps_code > `BCCD_WDPS_MAX) begin
      clk_cfg.wdog_postscale_sel = `BCCD_WDPS_MAX;
    end else begin
      clk_cfg.wdog_postscale_sel = ps_code;
    end
    clk_cfg.wdog_ratio = 21'h000001 << clk_cfg.wdog_postscale_sel;
    clk_cfg.clk_switch_en    = ~cksm[1];
    clk_cfg.fail_safe_mon_en = ~cksm[1] & ~cksm[0];
    clk_cfg.periph_bus_div_default =
      4'h1 << clk_wd_word[`BCCD_PBDIV_HI:`BCCD_PBDIV_LO];
    clk_cfg.clock_output_en = ~clk_wd_word[`BCCD_CLOCK_OUTPUT_DIS_BIT] &
      ((posc == `BCCD_POSC_OFF) || (posc == `BCCD_POSC_EXT));
    clk_cfg.primary_osc_mode = bccd_posc_t'(posc);
    clk_cfg.two_speed_startup_en = clk_wd_word[`BCCD_TWOSPD_BIT];
    clk_cfg.secondary_osc_en = clk_wd_word[`BCCD_SOSC_BIT];
    clk_cfg.initial_osc_sel =
      bccd_src_t'(clk_wd_word[`BCCD_NOSC_HI:`BCCD_NOSC_LO]);
  end

  // =========================================================================
  // pll word decode
  always_comb begin
    odiv = pll_word[`BCCD_PLLODIV_HI:`BCCD_PLLODIV_LO];
    if (odiv == 3'h7) begin
      pll_cfg.pll_output_div = 9'h100;
    end else begin
      pll_cfg.pll_output_div = 9'h001 << odiv;
    end
    pll_cfg.usb_pll_en = ~pll_word[`BCCD_UPLL_BYP_BIT];
    pll_cfg.usb_pll_input_div =
      in_div(pll_word[`BCCD_USB_PLL_INPUT_DIV_HI:`BCCD_USB_PLL_INPUT_DIV_LO]);
    if (pll_word[`BCCD_PLLMUL_HI:`BCCD_PLLMUL_LO] == 3'h7) begin
      pll_cfg.pll_multiplier = 5'h18;
    end else begin
      pll_cfg.pll_multiplier =
        5'h0f + {2'h0, pll_word[`BCCD_PLLMUL_HI:`BCCD_PLLMUL_LO]};
    end
    pll_cfg.pll_input_div =
      in_div(pll_word[`BCCD_PLLIDIV_HI:`BCCD_PLLIDIV_LO]);
  end

endmodule
`default_nettype wire

//--- rtl/bccd_top.sv
// bccd_top.sv: boot clock configuration decoder top level.
// assumes: configuration words arrive from nonvolatile memory and are
// valid while rst_b is low and on the first three clock edges after its release.
//
// Decided for this implementation: the address map and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
`include "bccd_defs.svh"

// How it works
// - watchdog enable bit 1 forces watchdog on; 0 lets software enable it.
// - five-bit postscale selects ratio two to the code, 1:1 to 1:1048576.
// - postscale codes above 10100 behave as 10100.
// - switch field 1x disables both, 01 switching only, 00 both.
// - peripheral bus default divisor is 1, 2, 4 or 8.
// - clock output drives only when enabled and primary mode is 11 or 00.
// - primary mode 11 off, 10 high-speed, 01 standard, 00 external.
// - switchover bit 1 enables two-speed start-up.
// - secondary oscillator enabled when its bit is 1.
// - initial source field picks one of eight start-up clocks.
// - pll output divider is 1,2,4,8,16,32,64 or 256.
// - usb pll enabled when its bit is 0, bypassed when 1.
// - usb pll input divider is 1,2,3,4,5,6,10 or 12.
// - pll multiplier is 15 to 21 or 24.
// - pll input divider is 1,2,3,4,5,6,10 or 12.
module bccd_top
  import bccd_pkg::*;
(
  input  wire logic          clock,
  input  wire logic          rst_b,
  input  wire logic [31:0]   nvm_clk_wd_word,
  input  wire logic [31:0]   nvm_pll_word,
  input  wire logic [3:0]    reg_addr,
  input  wire logic [31:0]   reg_wdata,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  output logic [31:0]        reg_rdata,
  output logic               cfg_valid,
  output var bccd_clk_cfg_t  clk_cfg,
  output var bccd_pll_cfg_t  pll_cfg,
  output logic               watchdog_unit_en,
  output logic               osc_out_pin_en
);

  bccd_state_t   state_r;
  bccd_state_t   state_nxt;
  logic [3:0]    cap_cnt_r;
  logic [31:0]   clk_wd_word_r;
  logic [31:0]   pll_word_r;
  bccd_clk_cfg_t clk_dec;
  bccd_pll_cfg_t pll_dec;
  logic          wdog_sw_en_r;
  logic          ill_start_r;
  logic          cap_last;

  // =========================================================================
  // capture sequencer: one capture after reset, then hold
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      BCCD_ST_RESET: begin
        state_nxt = BCCD_ST_CAPTURE;
      end
      BCCD_ST_CAPTURE: begin
        if (cap_cnt_r == `BCCD_CAPTURE_CYCLES) begin
          state_nxt = BCCD_ST_HOLD;
        end
      end
      BCCD_ST_HOLD: begin
        state_nxt = BCCD_ST_HOLD;
      end
      default: begin
        state_nxt = BCCD_ST_RESET;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= BCCD_ST_RESET;
    end else begin
      state_r <= state_nxt;
    end
  end

  // last capture cycle: outputs load, word registers freeze
  assign cap_last = (state_r == BCCD_ST_CAPTURE) &&
                    (cap_cnt_r == `BCCD_CAPTURE_CYCLES);

  // settle counter during capture
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cap_cnt_r <= 4'h0;
    end else if (state_r == BCCD_ST_CAPTURE) begin
      cap_cnt_r <= cap_cnt_r + 4'h1;
    end
  end

  // =========================================================================
  // word capture: sampled by clock after release, frozen in hold
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      clk_wd_word_r <= `BCCD_WORD_RESET;
      pll_word_r    <= `BCCD_WORD_RESET;
    end else if (state_r != BCCD_ST_HOLD && !cap_last) begin
      clk_wd_word_r <= nvm_clk_wd_word;
      pll_word_r    <= nvm_pll_word;
    end
  end

  bccd_field_dec u_dec (
    .clk_wd_word (clk_wd_word_r),
    .pll_word    (pll_word_r),
    .clk_cfg     (clk_dec),
    .pll_cfg     (pll_dec)
  );

  // =========================================================================
  // decoded outputs registered once words are stable
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      clk_cfg   <= '0;
      pll_cfg   <= '0;
      cfg_valid <= 1'b0;
    end else if (cap_last) begin
      clk_cfg   <= clk_dec;
      pll_cfg   <= pll_dec;
      cfg_valid <= 1'b1;
    end
  end

  // clock output pin enable follows the decoded setting
  assign osc_out_pin_en = cfg_valid & clk_cfg.clock_output_en;

  // flags a primary start source with primary oscillator disabled
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ill_start_r <= 1'b0;
    end else begin
      ill_start_r <= cfg_valid &&
        clk_cfg.primary_osc_mode == BCCD_POSC_DIS &&
        (clk_cfg.initial_osc_sel == BCCD_SRC_POSC ||
         clk_cfg.initial_osc_sel == BCCD_SRC_POSC_PLL);
    end
  end

  // =========================================================================
  // software watchdog enable; forced on when the config bit is set
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wdog_sw_en_r <= 1'b0;
    end else if (reg_wr && reg_addr == `BCCD_OFS_WDOG_CTRL) begin
      wdog_sw_en_r <= reg_wdata[0];
    end
  end

  assign watchdog_unit_en =
    cfg_valid & (clk_cfg.wdog_force_enable | wdog_sw_en_r);

  // =========================================================================
  // register read port, data one cycle after the strobe
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      case (reg_addr)
        `BCCD_OFS_CLKWD_WORD: reg_rdata <= clk_wd_word_r;
        `BCCD_OFS_PLL_WORD:   reg_rdata <= pll_word_r;
        `BCCD_OFS_STATUS:     reg_rdata <= {29'h0, ill_start_r,
                                            watchdog_unit_en, cfg_valid};
        `BCCD_OFS_WDOG_CTRL:  reg_rdata <= {31'h0, wdog_sw_en_r};
        `BCCD_OFS_DEC_CLK:    reg_rdata <= {12'h000,
                                            clk_cfg.wdog_force_enable,
                                            clk_cfg.wdog_postscale_sel,
                                            clk_cfg.clk_switch_en,
                                            clk_cfg.fail_safe_mon_en,
                                            clk_cfg.periph_bus_div_default,
                                            clk_cfg.clock_output_en,
                                            clk_cfg.primary_osc_mode,
                                            clk_cfg.two_speed_startup_en,
                                            clk_cfg.secondary_osc_en,
                                            clk_cfg.initial_osc_sel};
        `BCCD_OFS_DEC_PLL:    reg_rdata <= {9'h0, pll_cfg};
        default:              reg_rdata <= 32'h00000000;
      endcase
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

  // =========================================================================
  // checks: watchdog
  wdog_forced_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    (cfg_valid && clk_cfg.wdog_force_enable) |-> watchdog_unit_en)
    else $error("watchdog off while forced");

  wdog_swoff_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    (cfg_valid && !clk_cfg.wdog_force_enable && !wdog_sw_en_r)
      |-> !watchdog_unit_en)
    else $error("watchdog on without cause");

  wdog_swon_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    (cfg_valid && wdog_sw_en_r) |-> watchdog_unit_en)
    else $error("watchdog off after software enable");

  wdog_idle_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    !cfg_valid |-> (!watchdog_unit_en && !osc_out_pin_en))
    else $error("enable driven before settings loaded");

  ps_ratio_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    (cfg_valid && clk_wd_word_r[20:16] <= 5'h14)
      |-> clk_cfg.wdog_ratio == (21'h000001 << clk_wd_word_r[20:16]))
    else $error("postscale ratio mismatch");

  ps_onehot_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    cfg_valid |-> $onehot(clk_cfg.wdog_ratio))
    else $error("postscale ratio not a power of two");

  ps_clamp_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    (cfg_valid && clk_wd_word_r[20:16] > 5'h14)
      |-> (clk_cfg.wdog_ratio == 21'h100000 &&
           clk_cfg.wdog_postscale_sel == 5'h14))
    else $error("postscale code beyond range");

  // =========================================================================
  // checks: clock word
  cksm_dec_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    cfg_valid |-> (clk_cfg.fail_safe_mon_en -> clk_cfg.clk_switch_en)
      && (clk_cfg.clk_switch_en == ~clk_wd_word_r[15]))
    else $error("switch monitor decode wrong");

  fscm_dec_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    cfg_valid |-> clk_cfg.fail_safe_mon_en ==
      (clk_wd_word_r[15:14] == 2'h0))
    else $error("fail-safe monitor decode wrong");

  pbdiv_dec_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    cfg_valid |-> ($onehot(clk_cfg.periph_bus_div_default) &&
      clk_cfg.periph_bus_div_default[clk_wd_word_r[13:12]]))
    else $error("peripheral bus divisor decode wrong");

  clock_output_gate_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    osc_out_pin_en |-> (!clk_wd_word_r[10] &&
      (clk_wd_word_r[9:8] == 2'h3 || clk_wd_word_r[9:8] == 2'h0)))
    else $error("clock output driven when not allowed");

  clock_output_on_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    (cfg_valid && !clk_wd_word_r[10] &&
      (clk_wd_word_r[9:8] == 2'h3 || clk_wd_word_r[9:8] == 2'h0))
      |-> osc_out_pin_en)
    else $error("clock output idle when allowed");

  posc_mode_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    cfg_valid |-> clk_cfg.primary_osc_mode == clk_wd_word_r[9:8])
    else $error("primary oscillator mode wrong");

  two_speed_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    cfg_valid |-> clk_cfg.two_speed_startup_en == clk_wd_word_r[7])
    else $error("two-speed start-up enable wrong");

  sosc_en_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    cfg_valid |-> clk_cfg.secondary_osc_en == clk_wd_word_r[5])
    else $error("secondary oscillator enable wrong");

  init_src_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    cfg_valid |-> clk_cfg.initial_osc_sel == clk_wd_word_r[2:0])
    else $error("initial oscillator source wrong");

  ill_start_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    (cfg_valid && clk_cfg.primary_osc_mode == BCCD_POSC_DIS &&
      clk_cfg.initial_osc_sel[2:1] == 2'h1) |=> ill_start_r)
    else $error("disabled primary start source not flagged");

  // =========================================================================
  // checks: pll word
  odiv_dec_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    cfg_valid |-> ($onehot(pll_cfg.pll_output_div) &&
      pll_cfg.pll_output_div[(pll_word_r[18:16] == 3'h7) ? 4'h8 :
                             {1'b0, pll_word_r[18:16]}]))
    else $error("pll output divider wrong");

  upll_en_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    cfg_valid |-> pll_cfg.usb_pll_en == !pll_word_r[15])
    else $error("usb pll enable inverted");

  usb_idiv_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    cfg_valid |-> pll_cfg.usb_pll_input_div ==
      ((pll_word_r[10:9] != 2'h3) ? {1'b0, pll_word_r[10:8]} + 4'h1 :
       (pll_word_r[8] ? 4'hc : 4'ha)))
    else $error("usb pll input divider wrong");

  mul_map_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    cfg_valid |-> pll_cfg.pll_multiplier ==
      ((pll_word_r[6:4] == 3'h7) ? 5'h18 :
       5'h0f + {2'h0, pll_word_r[6:4]}))
    else $error("pll multiplier code map wrong");

  pll_mul_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    cfg_valid |-> (pll_cfg.pll_multiplier >= 5'h0f &&
      pll_cfg.pll_multiplier <= 5'h18 && pll_cfg.pll_multiplier != 5'h16
      && pll_cfg.pll_multiplier != 5'h17))
    else $error("pll multiplier out of set");

  pll_idiv_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    cfg_valid |-> pll_cfg.pll_input_div ==
      ((pll_word_r[2:1] != 2'h3) ? {1'b0, pll_word_r[2:0]} + 4'h1 :
       (pll_word_r[0] ? 4'hc : 4'ha)))
    else $error("pll input divider wrong");

  // =========================================================================
  // checks: capture, hold and read port
  cfg_hold_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    cfg_valid |=> ($stable(clk_cfg) && $stable(pll_cfg) && cfg_valid))
    else $error("decoded settings changed after capture");

  word_hold_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    cfg_valid |=> ($stable(clk_wd_word_r) && $stable(pll_word_r)))
    else $error("captured words changed after capture");

  cfg_zero_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    !cfg_valid |-> (clk_cfg == '0 && pll_cfg == '0))
    else $error("settings shown before capture");

  cap_time_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    $rose(state_r == BCCD_ST_CAPTURE) |-> ##3 cfg_valid)
    else $error("capture did not finish in time");

  rdata_idle_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    !reg_rd |=> reg_rdata == 32'h00000000)
    else $error("read data shown without a read");

endmodule
`default_nettype wire

//--- tb/tb_top.sv
// tb_top.sv: self-checking bench for the boot clock configuration decoder.
// assumes: rtl package and defs header compiled first; words set in reset.
`timescale 1ns/100ps
`default_nettype none
`include "bccd_defs.svh"

// compare two values, count it, report a mismatch
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin \
  failures++; $display("Error %s exp %h got %h", nm, exp, got); end end

module tb_top
  import bccd_pkg::*;
;
  logic          clock;
  logic          rst_b;
  logic [31:0]   nvm_clk_wd_word;
  logic [31:0]   nvm_pll_word;
  logic [3:0]    reg_addr;
  logic [31:0]   reg_wdata;
  logic          reg_wr;
  logic          reg_rd;
  logic [31:0]   reg_rdata;
  logic          cfg_valid;
  bccd_clk_cfg_t clk_cfg;
  bccd_pll_cfg_t pll_cfg;
  logic          watchdog_unit_en;
  logic          osc_out_pin_en;
  int            failures;
  int            tests_run;
  int            cycles;

  // postscale codes: low, boundary, above range
  localparam logic [4:0] WPS [8] = '{5'h00, 5'h01, 5'h13, 5'h14,
                                     5'h15, 5'h1f, 5'h05, 5'h0a};
  localparam logic [3:0] IDIV [8] = '{4'h1, 4'h2, 4'h3, 4'h4,
                                      4'h5, 4'h6, 4'ha, 4'hc};
  localparam logic [4:0] MUL [8] = '{5'h0f, 5'h10, 5'h11, 5'h12,
                                     5'h13, 5'h14, 5'h15, 5'h18};

  bccd_top i_dut (
    .clock            (clock),
    .rst_b            (rst_b),
    .nvm_clk_wd_word  (nvm_clk_wd_word),
    .nvm_pll_word     (nvm_pll_word),
    .reg_addr         (reg_addr),
    .reg_wdata        (reg_wdata),
    .reg_wr           (reg_wr),
    .reg_rd           (reg_rd),
    .reg_rdata        (reg_rdata),
    .cfg_valid        (cfg_valid),
    .clk_cfg          (clk_cfg),
    .pll_cfg          (pll_cfg),
    .watchdog_unit_en (watchdog_unit_en),
    .osc_out_pin_en   (osc_out_pin_en)
  );

  // ==========================================================================
  // clock and hang guard
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      tally_and_finish();
    end
  end

  // ==========================================================================
  // verdict
  task automatic tally_and_finish();
    if (failures == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // configuration words, reserved bits left at one
  function automatic logic [31:0] mk1(input logic [2:0] c);
    logic [31:0] w;
    w = 32'hffffffff;
    w[23] = c[0];
    w[20:16] = WPS[c];
    w[15:14] = c[1:0];
    w[13:12] = c[2:1];
    w[10] = c[2];
    w[9:8] = c[1:0];
    w[7] = c[2];
    w[5] = c[0];
    w[2:0] = c;
    return w;
  endfunction

  function automatic logic [31:0] mk2(input logic [2:0] c);
    logic [31:0] w;
    w = 32'hffffffff;
    w[18:16] = c;
    w[15] = c[0];
    w[10:8] = ~c;
    w[6:4] = c;
    w[2:0] = ~c;
    return w;
  endfunction

  // ==========================================================================
  // register port cycles
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  // reset with the given words, then wait for the load
  task automatic boot(input logic [31:0] w1, input logic [31:0] w2);
    int n;
    @(posedge clock);
    rst_b <= 1'b0;
    nvm_clk_wd_word <= w1;
    nvm_pll_word <= w2;
    repeat (16) @(posedge clock);
    `CHK("valid_in_reset", 1'b0, cfg_valid)
    rst_b <= 1'b1;
    n = 0;
    while (cfg_valid !== 1'b1 && n < 20) begin
      @(posedge clock);
      n++;
    end
    #1;
    `CHK("cfg_valid", 1'b1, cfg_valid)
  endtask

  // ==========================================================================
  // main sequence: eight configurations cover every code of each field except the five-bit postscale (eight of its codes)
  initial begin
    logic [31:0]   w1;
    logic [31:0]   w2;
    logic [31:0]   d;
    logic [2:0]    c;
    logic [4:0]    ps;
    logic [8:0]    od;
    logic          co;
    bccd_clk_cfg_t held;
    rst_b = 1'b0;
    nvm_clk_wd_word = 32'hffffffff;
    nvm_pll_word = 32'hffffffff;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    for (int i = 0; i < 8; i++) begin
      c = i[2:0];
      w1 = mk1(c);
      w2 = mk2(c);
      boot(w1, w2);
      ps = (WPS[c] > 5'h14) ? 5'h14 : WPS[c];
      co = ~w1[10] & (w1[9:8] == 2'b11 || w1[9:8] == 2'b00);
      `CHK("force_en", w1[23], clk_cfg.wdog_force_enable)
      `CHK("wd_ratio", 21'h1 << ps, clk_cfg.wdog_ratio)
      `CHK("switch_en", ~c[1], clk_cfg.clk_switch_en)
      `CHK("monitor_en", c[1:0] == 2'b00, clk_cfg.fail_safe_mon_en)
      `CHK("pb_div", 4'h1 << c[2:1], clk_cfg.periph_bus_div_default)
      `CHK("clock_output_cfg", co, clk_cfg.clock_output_en)
      `CHK("clock_output_pin", co, osc_out_pin_en)
      `CHK("posc_mode", bccd_posc_t'(c[1:0]), clk_cfg.primary_osc_mode)
      `CHK("two_speed", c[2], clk_cfg.two_speed_startup_en)
      `CHK("sosc_en", c[0], clk_cfg.secondary_osc_en)
      `CHK("init_src", bccd_src_t'(c), clk_cfg.initial_osc_sel)
      od = (c == 3'h7) ? 9'h100 : 9'h001 << c;
      `CHK("pll_odiv", od, pll_cfg.pll_output_div)
      `CHK("usb_pll_en", ~c[0], pll_cfg.usb_pll_en)
      `CHK("usb_idiv", IDIV[~c], pll_cfg.usb_pll_input_div)
      `CHK("pll_mul", MUL[c], pll_cfg.pll_multiplier)
      `CHK("pll_idiv", IDIV[~c], pll_cfg.pll_input_div)
      `CHK("wd_run_boot", w1[23], watchdog_unit_en)
      wr(4'h3, 32'h0);
      `CHK("wd_run_off", w1[23], watchdog_unit_en)
      wr(4'h3, 32'h1);
      `CHK("wd_run_on", 1'b1, watchdog_unit_en)
      rd(4'h2, d);
      `CHK("status", {29'h0, c == 3'h3, 2'b11}, d)
      // new words and a write to the word address must not disturb it
      held = clk_cfg;
      nvm_clk_wd_word <= ~w1;
      nvm_pll_word <= ~w2;
      wr(4'h0, 32'h0);
      repeat (4) @(posedge clock);
      #1;
      `CHK("held_cfg", held, clk_cfg)
      rd(4'h0, d);
      `CHK("word1_rd", w1, d)
      rd(4'h1, d);
      `CHK("word2_rd", w2, d)
      rd(4'h3, d);
      `CHK("wd_ctrl_rd", 32'h1, d)
      rd(4'h4, d);
      `CHK("dec_clk_rd", {12'h0, w1[23], ps, ~c[1], c[1:0] == 2'b00,
           4'h1 << c[2:1], co, c[1:0], c[2], c[0], c}, d)
      rd(4'h5, d);
      `CHK("dec_pll_rd", {9'h0, od, ~c[0], IDIV[~c], MUL[c], IDIV[~c]},
           d)
    end
    rd(4'hf, d);
    `CHK("unmapped", 32'h0, d)
    tally_and_finish();
  end

endmodule

`default_nettype wire
